/* inc/sense_defs.vh */
`ifndef SENSE_DEFS_VH
`define SENSE_DEFS_VH

`define REC_LEN          6'd32
`define LAST_IDX         5'd31
`define RESP_CURRENT     7'h70
`define RESP_DEFERRED    7'h71
`define ADD_SENSE_LEN    8'h18
`define INFO_MAX         33'h0FFFFFFFF

`define KEY_NO_SENSE     4'h0
`define KEY_RECOVERED    4'h1
`define KEY_NOT_READY    4'h2
`define KEY_MEDIUM       4'h3
`define KEY_HARDWARE     4'h4
`define KEY_ILLEGAL      4'h5
`define KEY_UNIT_ATTN    4'h6
`define KEY_DATA_PROTECT 4'h7
`define KEY_ABORTED      4'hB
`define KEY_MISCOMPARE   4'hE
`define KEY_COMPLETED    4'hF

`define ASC_SMART_0B     8'h0B
`define ASC_SMART_5D     8'h5D

`define WARN_NONE        4'h0
`define WARN_TEMP        4'h1
`define WARN_SELFTEST    4'h2
`define WARN_PRESCAN     4'h3
`define WARN_MEDIASCAN   4'h4
`define WARN_OVERTEMP    4'h5
`define WARN_MILLIACT    4'h6
`define WARN_LOADCYC     4'h7
`define WARN_SPINRETRY   4'h8
`define WARN_FWRISK      4'h9
`define WARN_READ_RATE   4'hA
`define WARN_WRITE_RATE  4'hB
`define WARN_SEEK_RATE   4'hC

`define BYTE_RESP        5'd0
`define BYTE_KEY         5'd2
`define BYTE_INFO        5'd3
`define BYTE_ADDLEN      5'd7
`define BYTE_ASC         5'd12
`define BYTE_ASCQ        5'd13
`define ILI_BIT          5

`endif

/* rtl/sense_builder.v */
// Summary of operation
// - Sense key sits in byte 2 bits 3..0.
// - Key 0h means nothing to report.
// - Key 1h means success after recovery; details in code and qualifier.
// - Key 2h means the logical unit cannot be accessed.
// - Key 3h means unrecoverable media or recorded data error.
// - Key 4h means unrecoverable hardware error in command or diagnostic.
// - Key 5h for bad command block leaves medium untouched.
// - Key 6h means unit attention condition entered.
// - Key Bh for aborted; 7h, Eh, Fh allowed; 8h, Ah, Ch, Dh never sent.
// - Information field is zero whenever valid is zero.
// - Valid with length bit clear carries the unsigned block address.
// - Block reassignment may report an address other than its own.
// - Values beyond four bytes clear valid rather than truncate.
// - Valid with length bit set carries two's complement byte residue.
// - Additional sense length byte is always 18h.
// - Bytes 8 to 11 are always zero.
// - Code in byte 12, qualifier in 13; all zero with no information.
// - Code 0B qualifiers 01, 03, 04, 05 for SMART warnings.
// - Code 5D qualifiers 20, 21, 50 for those warnings.
// - Code 5D qualifiers 5B, 61, 63 for those warnings.
// - Read and write error rate both use 5D/62.
// - SMART warnings may use key no sense, recovered or unit attention; with a reserved key the code sends them under aborted (Bh).
// - The record is exactly 32 bytes.
// - Byte 0 holds 70h current or 71h deferred, valid in bit 7.
// - Length bit, byte 2 bit 5, only for long read or write mismatch.
`timescale 1ns/1ps
`default_nettype none
`include "sense_defs.vh"

module sense_builder (
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire        START_I,
  input  wire        DEFERRED_I,
  input  wire [3:0]  KEY_I,
  input  wire [3:0]  WARN_I,
  input  wire [7:0]  ASC_I,
  input  wire [7:0]  ASCQ_I,
  input  wire        INFO_VALID_I,
  input  wire [32:0] INFO_I,
  input  wire        LONG_CMD_I,
  input  wire        LEN_MISMATCH_I,
  input  wire [31:0] RESIDUE_I,
  output wire        BUSY_O,
  output reg         BYTE_VALID_O,
  output reg  [7:0]  BYTE_O,
  output reg  [4:0]  BYTE_IDX_O,
  output reg         LAST_O,
  output wire        KEY_REJECT_O
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  reg  [1:0]   state_q;
  reg  [1:0]   state_d;
  reg  [255:0] rec_q;
  wire [255:0] rec_d;
  reg  [4:0]   cnt_q;
  reg  [4:0]   cnt_d;
  reg  [3:0]   key_use;
  reg  [7:0]   asc_use;
  reg  [7:0]   ascq_use;
  reg          smart;
  reg          smart_key;
  reg          ili;
  reg          valid;
  reg  [31:0]  info;
  reg          bad_key;
  reg  [7:0]   resp_byte;
  reg  [7:0]   key_byte;
  reg  [7:0]   byte_sel;
  wire         take;
  wire         at_end;

  // Reserved sense key codes are refused and reported as aborted
  always @* begin
    case (KEY_I)
      4'h0:    bad_key = 1'b0;
      4'h1:    bad_key = 1'b0;
      4'h2:    bad_key = 1'b0;
      4'h3:    bad_key = 1'b0;
      4'h4:    bad_key = 1'b0;
      4'h5:    bad_key = 1'b0;
      4'h6:    bad_key = 1'b0;
      4'h7:    bad_key = 1'b0;
      4'h8:    bad_key = 1'b1;
      4'h9:    bad_key = 1'b1;
      4'hA:    bad_key = 1'b1;
      4'hB:    bad_key = 1'b0;
      4'hC:    bad_key = 1'b1;
      4'hD:    bad_key = 1'b1;
      4'hE:    bad_key = 1'b0;
      4'hF:    bad_key = 1'b0;
      default: bad_key = 1'b0;
    endcase
  end

  // Keys that may carry a warning unchanged
  always @* begin
    case (KEY_I)
      `KEY_NO_SENSE:  smart_key = 1'b1;
      `KEY_RECOVERED: smart_key = 1'b1;
      `KEY_UNIT_ATTN: smart_key = 1'b1;
      default:        smart_key = 1'b0;
    endcase
  end

  assign take         = START_I && (state_q == ST_IDLE);
  assign at_end       = (state_q == ST_SEND) && (cnt_q == `LAST_IDX);
  assign KEY_REJECT_O = take && bad_key;
  assign BUSY_O       = (state_q == ST_SEND);

  // Code and qualifier from warning selector, else direct
  always @* begin
    key_use  = bad_key ? `KEY_ABORTED : KEY_I;
    asc_use  = ASC_I;
    ascq_use = ASCQ_I;
    smart    = 1'b1;
    case (WARN_I)
      `WARN_TEMP: begin
        asc_use  = `ASC_SMART_0B;
        ascq_use = 8'h01;
      end
      `WARN_SELFTEST: begin
        asc_use  = `ASC_SMART_0B;
        ascq_use = 8'h03;
      end
      `WARN_PRESCAN: begin
        asc_use  = `ASC_SMART_0B;
        ascq_use = 8'h04;
      end
      `WARN_MEDIASCAN: begin
        asc_use  = `ASC_SMART_0B;
        ascq_use = 8'h05;
      end
      `WARN_OVERTEMP: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h20;
      end
      `WARN_MILLIACT: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h21;
      end
      `WARN_LOADCYC: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h50;
      end
      `WARN_SPINRETRY: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h5B;
      end
      `WARN_FWRISK: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h61;
      end
      `WARN_READ_RATE: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h62;
      end
      `WARN_WRITE_RATE: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h62;
      end
      `WARN_SEEK_RATE: begin
        asc_use  = `ASC_SMART_5D;
        ascq_use = 8'h63;
      end
      default: begin
        smart = 1'b0;
      end
    endcase
    // Warnings keep their pair under the no sense, recovered or attention keys
    if (smart && !bad_key && !smart_key) begin
      key_use = `KEY_NO_SENSE;
    end
  end

  // Information field and flags
  always @* begin
    ili   = LONG_CMD_I && LEN_MISMATCH_I && INFO_VALID_I;
    valid = 1'b0;
    info  = 32'h00000000;
    if (ili) begin
      valid = 1'b1;
      info  = RESIDUE_I;
    end else if (INFO_VALID_I && INFO_I <= `INFO_MAX) begin
      valid = 1'b1;
      info  = INFO_I[31:0];
    end
  end

  // Response byte carries the valid flag above the code
  always @* begin
    if (DEFERRED_I) begin
      resp_byte = {valid, `RESP_DEFERRED};
    end else begin
      resp_byte = {valid, `RESP_CURRENT};
    end
  end

  // Key byte: two zero bits, length flag, zero bit, key
  always @* begin
    key_byte = {2'b00, ili, 1'b0, key_use};
  end

  // One builder per record byte, byte n at bits 8n+7..8n
  genvar g;
  generate
    for (g = 0; g < `REC_LEN; g = g + 1) begin : g_byte
      reg [7:0] val;
      always @* begin
        if (g == `BYTE_RESP) begin
          val = resp_byte;
        end else if (g == `BYTE_KEY) begin
          val = key_byte;
        end else if (g == `BYTE_INFO) begin
          val = info[31:24];
        end else if (g == (`BYTE_INFO + 1)) begin
          val = info[23:16];
        end else if (g == (`BYTE_INFO + 2)) begin
          val = info[15:8];
        end else if (g == (`BYTE_INFO + 3)) begin
          val = info[7:0];
        end else if (g == `BYTE_ADDLEN) begin
          val = `ADD_SENSE_LEN;
        end else if (g == `BYTE_ASC) begin
          val = asc_use;
        end else if (g == `BYTE_ASCQ) begin
          val = ascq_use;
        end else begin
          val = 8'h00;
        end
      end
      assign rec_d[8*g +: 8] = val;
    end
  endgenerate

  // Byte under the counter
  always @* begin
    byte_sel = rec_q[8*cnt_q +: 8];
  end

  // Idle waits for a request, send walks all 32 bytes
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 5'h00;
        if (START_I) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == `LAST_IDX) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 5'h00;
      end
    endcase
  end

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Whole record is captured at the take so inputs may move during sending
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      rec_q <= 256'h0;
    end else if (take) begin
      rec_q <= rec_d;
    end
  end

  // Output stage: one byte per cycle, last flag with byte 31
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      BYTE_VALID_O <= 1'b0;
      BYTE_O       <= 8'h00;
      BYTE_IDX_O   <= 5'h00;
      LAST_O       <= 1'b0;
    end else begin
      BYTE_VALID_O <= BUSY_O;
      LAST_O       <= at_end;
      if (BUSY_O) begin
        BYTE_O     <= byte_sel;
        BYTE_IDX_O <= cnt_q;
      end
    end
  end

endmodule // sense_builder
`default_nettype wire

/* test/sense_builder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_builder_properties (
  input wire logic CLK_I, RESET_I, START_I, BUSY_O, BYTE_VALID_O, LAST_O, KEY_REJECT_O,
  input wire logic [3:0] KEY_I,
  input wire logic [7:0] BYTE_O,
  input wire logic [4:0] BYTE_IDX_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  wire take = START_I && !BUSY_O;
  wire [5:0] at = {BYTE_VALID_O, BYTE_IDX_O};
  a_take_answer: assert property (take |=> BUSY_O ##1 at == 6'h20) else $error("late byte");
  a_last_byte: assert property (LAST_O |-> at == 6'h3F && !BUSY_O) else $error("bad last");
  a_idx_step: assert property (BYTE_VALID_O && !LAST_O |=>
    at == {1'b1, $past(BYTE_IDX_O) + 5'h01}) else $error("index skipped");
  a_resp_code: assert property (at == 6'h20 |-> BYTE_O[6:1] == 6'h38) else $error("bad code");
  a_key_byte: assert property (at == 6'h22 |-> BYTE_O[7:6] == 2'h0 && !BYTE_O[4]
    && !(BYTE_O[3:0] inside {8, 9, 10, 12, 13})) else $error("bad key");
  a_add_len: assert property (at == 6'h27 |-> BYTE_O == 8'h18) else $error("bad length");
  a_cmd_zero: assert property (at inside {[6'h28:6'h2B]} |-> BYTE_O == 8'h00) else $error("cmd");
  a_tail_zero: assert property (at > 6'h2D |-> BYTE_O == 8'h00) else $error("stale tail");
  a_key_refuse: assert property (take && KEY_I inside {8, 9, 10, 12, 13} |-> KEY_REJECT_O)
    else $error("no refuse");
  cover property (take);
  cover property (LAST_O);
  cover property (KEY_REJECT_O);
endmodule // sense_builder_properties
bind sense_builder sense_builder_properties chk (.*);
`default_nettype wire

/* test/sense_initiator.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_initiator (
  input  wire logic         clk_i, valid_i,
  input  wire logic [7:0]   byte_i,
  input  wire logic [4:0]   idx_i,
  output var  logic [255:0] rec_o,
  output var  int           n_o
);
  // Byte 0 lands on top so the record reads as one word
  always @(posedge clk_i) begin
    if (valid_i) begin
      rec_o[8 * (31 - idx_i) +: 8] <= byte_i;
      n_o <= (idx_i == 5'h00) ? 1 : n_o + 1;
    end
  end
endmodule // sense_initiator
`default_nettype wire

/* test/sense_builder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_builder_test;
  logic CLK_I = 0, RESET_I = 1, START_I = 0, DEFERRED_I = 0, INFO_VALID_I = 0;
  logic LONG_CMD_I = 0, LEN_MISMATCH_I = 0, BUSY_O, BYTE_VALID_O, LAST_O, KEY_REJECT_O;
  logic [3:0] KEY_I = 0, WARN_I = 0;
  logic [7:0] ASC_I = 0, ASCQ_I = 0, BYTE_O;
  logic [32:0] INFO_I = 0;
  logic [31:0] RESIDUE_I = 0;
  logic [4:0] BYTE_IDX_O;
  logic [255:0] rec;
  int n_bytes, n_errors = 0, total_checks = 0, cyc = 0;
  localparam logic [15:0] TBL [12] = '{16'h0B01, 16'h0B03, 16'h0B04, 16'h0B05, 16'h5D20,
    16'h5D21, 16'h5D50, 16'h5D5B, 16'h5D61, 16'h5D62, 16'h5D62, 16'h5D63};
  sense_builder uut (.*);
  sense_initiator host (.clk_i(CLK_I), .valid_i(BYTE_VALID_O), .byte_i(BYTE_O),
    .idx_i(BYTE_IDX_O), .rec_o(rec), .n_o(n_bytes));
  initial forever #12.5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up;
    end
  end
  task check(input logic [255:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t %h %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task run(input logic d, logic [3:0] k, w, logic [7:0] a, q, logic v, logic [32:0] i,
           logic l, m, logic [31:0] r);
    @(posedge CLK_I);
    {START_I, DEFERRED_I, KEY_I, WARN_I, ASC_I, ASCQ_I, INFO_VALID_I, INFO_I, LONG_CMD_I,
     LEN_MISMATCH_I, RESIDUE_I} <= {1'b1, d, k, w, a, q, v, i, l, m, r};
    @(posedge CLK_I) START_I <= 0;
    for (int n = 0; n < 40 && !LAST_O; n++) @(posedge CLK_I);
    #1;
    check(n_bytes, 32);
  endtask
  function logic [255:0] rx(logic [7:0] b0, b2, logic [31:0] i, logic [7:0] a, q);
    return {b0, 8'h00, b2, i, 8'h18, 32'h0, a, q, 144'h0};
  endfunction
  task t_keys;
    for (logic [4:0] k = 5'h00; k < 5'h10; k++) begin
      run(0, k[3:0], 0, 8'h11, 8'h22, 0, '0, 0, 0, '0);
      check(rec, rx(8'h70, k inside {8, 9, 10, 12, 13} ? 8'h0B : {3'h0, k}, '0, 8'h11, 8'h22));
    end
  endtask
  task t_warn;
    logic [3:0] k;
    for (int w = 1; w < 13; w++) begin
      k = (w % 3 == 0) ? 4'h6 : 4'(w % 3 - 1);
      run(0, k, 4'(w), 8'hAA, 8'hAA, 0, '0, 0, 0, '0);
      check(rec, rx(8'h70, {4'h0, k}, '0, TBL[w-1][15:8], TBL[w-1][7:0]));
    end
    run(0, 4'h2, 4'h1, 8'hAA, 8'hAA, 0, '0, 0, 0, '0);
    check(rec, rx(8'h70, 8'h00, '0, 8'h0B, 8'h01));
    run(0, 4'h2, 4'hD, 8'h3A, 8'h43, 0, '0, 0, 0, '0);
    check(rec, rx(8'h70, 8'h02, '0, 8'h3A, 8'h43));
  endtask
  task t_reset;
    @(posedge CLK_I) START_I <= 1;
    @(posedge CLK_I) START_I <= 0;
    repeat (10) @(posedge CLK_I);
    RESET_I <= 1;
    repeat (2) @(posedge CLK_I);
    RESET_I <= 0;
    #1;
    check({BUSY_O, BYTE_VALID_O, LAST_O}, 0);
    run(0, 4'h4, 0, 8'h44, 8'h00, 0, '0, 0, 0, '0);
    check(rec, rx(8'h70, 8'h04, '0, 8'h44, 8'h00));
  endtask
  task t_info;
    run(1, 4'h3, 0, '0, '0, 1, 33'h012345678, 0, 0, '0);
    check(rec, rx(8'hF1, 8'h03, 32'h12345678, '0, '0));
    run(0, 4'h3, 0, '0, '0, 1, 33'h100000000, 0, 0, '0);
    check(rec, rx(8'h70, 8'h03, '0, '0, '0));
    run(0, 4'h3, 0, '0, '0, 1, 33'h0AAAA5555, 1, 1, 32'hFFFFFFFC);
    check(rec, rx(8'hF0, 8'h23, 32'hFFFFFFFC, '0, '0));
    run(0, 4'h3, 0, '0, '0, 1, 33'h0AAAA5555, 1, 0, 32'hFFFFFFFC);
    check(rec, rx(8'hF0, 8'h03, 32'hAAAA5555, '0, '0));
    run(0, 4'h3, 0, '0, '0, 0, 33'h0AAAA5555, 0, 0, '0);
    check(rec, rx(8'h70, 8'h03, '0, '0, '0));
  endtask
  initial begin
    repeat (16) @(posedge CLK_I);
    RESET_I <= 0;
    t_keys;
    t_warn;
    t_info;
    t_reset;
    wrap_up;
  end
endmodule // sense_builder_test
`default_nettype wire
